// [logic/clfr_defs.vh]
// Constants for the current-limit fault response block.
// Assumes a 250 MHz ref_clk and a 32-bit Avalon-MM register port.
`ifndef CLFR_DEFS_VH
`define CLFR_DEFS_VH

// Register byte offsets
`define CLFR_OFS_SETUP       8'h00
`define CLFR_OFS_STATUS      8'h04
`define CLFR_OFS_MASK        8'h08
`define CLFR_OFS_STATE       8'h0C
`define CLFR_OFS_CONTROL     8'h10

// Field positions inside fault_setup_one
`define CLFR_CBC_MODE_LSB    23
`define CLFR_LOCK_THR_LSB    19
`define CLFR_LOCK_MODE_LSB   15
`define CLFR_LOCK_DEG_LSB    11
`define CLFR_RETRY_LSB       8

// Reset values
`define CLFR_SETUP_RST       32'h0000_0000
`define CLFR_MASK_RST        2'h0

// Status and control bits
`define CLFR_ST_CBC          0
`define CLFR_ST_LOCK         1
`define CLFR_CTL_CLEAR       0

// Response code limits
`define CLFR_CBC_REPORT      4'h6
`define CLFR_LOCK_REPORT     4'h8

// Timing
`define CLFR_CLK_PERIOD_NS   4
`define CLFR_MS_NS           1000000
`define CLFR_LOCK_RETRY_MS   16'h01F4

// Lock deglitch times in ms, codes 0h..Fh
`define CLFR_DEG_MS_0        16'h0001
`define CLFR_DEG_MS_1        16'h0002
`define CLFR_DEG_MS_2        16'h0005
`define CLFR_DEG_MS_3        16'h000A
`define CLFR_DEG_MS_4        16'h0019
`define CLFR_DEG_MS_5        16'h0032
`define CLFR_DEG_MS_6        16'h004B
`define CLFR_DEG_MS_7        16'h0064
`define CLFR_DEG_MS_8        16'h00FA
`define CLFR_DEG_MS_9        16'h01F4
`define CLFR_DEG_MS_A        16'h03E8
`define CLFR_DEG_MS_B        16'h09C4
`define CLFR_DEG_MS_C        16'h1388
`define CLFR_DEG_MS_D        16'h2710
`define CLFR_DEG_MS_E        16'h61A8
`define CLFR_DEG_MS_F        16'hC350

`endif

// [logic/clfr_top.v]
// Current-limit fault response: cycle-by-cycle limit and lock detection.
// Assumes sense samples and PWM cycle starts synchronous to ref_clk.
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`include "clfr_defs.vh"
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Field 26-23 codes 0h/1h: recirculate, resume next PWM cycle; 0h flags pin.
// - Codes 2h/3h: recirculate until sense below limit; 2h flags; high-side modulation only.
// - Codes 4h/5h: recirculate for retry count of PWM cycles; 4h flags pin.
// - Code 6h: report over-limit only, bridge drive untouched.
// - Codes 7h to Fh: cycle-by-cycle limiting disabled.
// - Field 22-19 lock threshold: 0h none, 1h..Fh give 0.1 V steps.
// - Lock field 18-15 codes 0h-3h latch, flag pin, select safe bridge state.
// - Lock codes 4h-7h: same bridge states, resume after lock retry interval.
// - Lock code 8h: report detection only, no bridge action.
// - Lock codes 9h to Fh: lock detection disabled.
// - High-side brake turns all high sides on; low-side brake all low sides.
// - Lock declared only after deglitch time chosen by bits 14-11.
// - Bits 10-8 give 0 to 7 PWM cycles before cycle limit retries.
module clfr_top #(
   parameter ADC_W     = 12,
   parameter STEP_CNT  = 100,
   parameter MS_CYCLES = `CLFR_MS_NS / `CLFR_CLK_PERIOD_NS
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire [7:0]       avs_address,
   input  wire             avs_read,
   input  wire             avs_write,
   input  wire [31:0]      avs_writedata,
   output reg  [31:0]      avs_readdata,
   output reg              avs_waitrequest,
   input  wire [ADC_W-1:0] sense_amp_output_voltage,
   input  wire [ADC_W-1:0] cycle_limit_threshold,
   input  wire             pwm_cycle_start,
   input  wire             high_side_modulation,
   input  wire [2:0]       drive_hs,
   input  wire [2:0]       drive_ls,
   output reg  [2:0]       gate_hs_q,
   output reg  [2:0]       gate_ls_q,
   output reg              fault_indicator_pin_n_q,
   output reg              irq_q
);

   localparam [ADC_W-1:0] STEP_V  = STEP_CNT[ADC_W-1:0];
   localparam [17:0]      MS_LAST = MS_CYCLES[17:0] - 18'h0_0001;

   localparam [1:0] CBC_RUN  = 2'b01;
   localparam [1:0] CBC_HOLD = 2'b10;
   localparam [2:0] LK_IDLE  = 3'b001;
   localparam [2:0] LK_LATCH = 3'b010;
   localparam [2:0] LK_RETRY = 3'b100;

   // Bridge state selector
   localparam [2:0] BR_NORMAL = 3'h0;
   localparam [2:0] BR_TRI    = 3'h1;
   localparam [2:0] BR_RECIRC = 3'h2;
   localparam [2:0] BR_HSBRK  = 3'h3;
   localparam [2:0] BR_LSBRK  = 3'h4;

   function [15:0] deg_ms;
      input [3:0] code;
      begin
         case (code)
            4'h0: deg_ms = `CLFR_DEG_MS_0;
            4'h1: deg_ms = `CLFR_DEG_MS_1;
            4'h2: deg_ms = `CLFR_DEG_MS_2;
            4'h3: deg_ms = `CLFR_DEG_MS_3;
            4'h4: deg_ms = `CLFR_DEG_MS_4;
            4'h5: deg_ms = `CLFR_DEG_MS_5;
            4'h6: deg_ms = `CLFR_DEG_MS_6;
            4'h7: deg_ms = `CLFR_DEG_MS_7;
            4'h8: deg_ms = `CLFR_DEG_MS_8;
            4'h9: deg_ms = `CLFR_DEG_MS_9;
            4'hA: deg_ms = `CLFR_DEG_MS_A;
            4'hB: deg_ms = `CLFR_DEG_MS_B;
            4'hC: deg_ms = `CLFR_DEG_MS_C;
            4'hD: deg_ms = `CLFR_DEG_MS_D;
            4'hE: deg_ms = `CLFR_DEG_MS_E;
            default: deg_ms = `CLFR_DEG_MS_F;
         endcase
      end
   endfunction

   // Safe state for lock codes, low two bits pick the state
   function [2:0] lock_state;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: lock_state = BR_TRI;
            2'h1: lock_state = BR_RECIRC;
            2'h2: lock_state = BR_HSBRK;
            default: lock_state = BR_LSBRK;
         endcase
      end
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   // Registers
   reg [31:0]      setup_q;
   reg [31:0]      cfg_q;
   reg [1:0]       status_q;
   reg [1:0]       mask_q;
   reg [1:0]       cbc_q;
   reg [2:0]       lk_q;
   reg [2:0]       retry_cnt_q;
   reg [17:0]      ms_cnt_q;
   reg             ms_tick_q;
   reg [15:0]      deg_cnt_q;
   reg [15:0]      lk_ms_q;
   reg [2:0]       br_sel_q;

   wire [3:0] cbc_mode  = cfg_q[`CLFR_CBC_MODE_LSB +: 4];
   wire [3:0] lk_thr    = cfg_q[`CLFR_LOCK_THR_LSB +: 4];
   wire [3:0] lk_mode   = cfg_q[`CLFR_LOCK_MODE_LSB +: 4];
   wire [3:0] lk_deg    = cfg_q[`CLFR_LOCK_DEG_LSB +: 4];
   wire [2:0] cbc_retry = cfg_q[`CLFR_RETRY_LSB +: 3];

   wire [ADC_W+3:0] lk_thr_v = lk_thr * STEP_V;
   wire over_cbc  = sense_amp_output_voltage > cycle_limit_threshold;
   wire over_lock = (lk_thr != 4'h0) && ({4'h0, sense_amp_output_voltage} >= lk_thr_v);
   wire cbc_act   = cbc_mode < `CLFR_CBC_REPORT;
   wire cbc_on    = cbc_mode <= `CLFR_CBC_REPORT;
   wire lk_on     = lk_mode <= `CLFR_LOCK_REPORT;
   wire lk_found  = lk_on && over_lock && ms_tick_q && (deg_cnt_q >= deg_ms(lk_deg) - 16'h0001);
   wire cbc_event = cbc_on && over_cbc && (cbc_q == CBC_RUN) && (lk_q == LK_IDLE);

   wire bus_req   = (avs_read || avs_write) && avs_waitrequest;
   wire wr_take   = avs_write && !avs_waitrequest;
   wire fault_clr = wr_take && (avs_address == `CLFR_OFS_CONTROL) && avs_writedata[`CLFR_CTL_CLEAR];

   //////////////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait cycle, write lands at the edge waitrequest is low
   always @(posedge ref_clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         setup_q         <= `CLFR_SETUP_RST;
         mask_q          <= `CLFR_MASK_RST;
      end else begin
         avs_waitrequest <= !bus_req;
         if (bus_req && avs_read) begin
            case (avs_address)
               `CLFR_OFS_SETUP:  avs_readdata <= setup_q;
               `CLFR_OFS_STATUS: avs_readdata <= {30'h0000_0000, status_q};
               `CLFR_OFS_MASK:   avs_readdata <= {30'h0000_0000, mask_q};
               `CLFR_OFS_STATE:  avs_readdata <= {25'h000_0000, br_sel_q, !fault_indicator_pin_n_q,
                                                  lk_q[2:1], cbc_q[1]};
               default:          avs_readdata <= 32'h0000_0000;
            endcase
         end
         if (wr_take && avs_address == `CLFR_OFS_SETUP) begin
            setup_q <= avs_writedata;
         end
         if (wr_take && avs_address == `CLFR_OFS_MASK) begin
            mask_q <= avs_writedata[1:0];
         end
      end
   end

   // Sticky status, set wins over write-one-to-clear
   always @(posedge ref_clk) begin
      if (rst) begin
         status_q <= 2'h0;
         irq_q    <= 1'b0;
      end else begin
         status_q <= (status_q & ~((wr_take && avs_address == `CLFR_OFS_STATUS) ? avs_writedata[1:0] : 2'h0))
                     | {lk_found, cbc_event};
         irq_q    <= |(status_q & mask_q);
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Settings follow the PWM cycle boundary
   always @(posedge ref_clk) begin
      if (rst) begin
         cfg_q <= `CLFR_SETUP_RST;
      end else if (pwm_cycle_start) begin
         cfg_q <= setup_q;
      end
   end

   // Millisecond tick
   always @(posedge ref_clk) begin
      if (rst) begin
         ms_cnt_q  <= 18'h0_0000;
         ms_tick_q <= 1'b0;
      end else begin
         ms_tick_q <= (ms_cnt_q == MS_LAST);
         ms_cnt_q  <= (ms_cnt_q == MS_LAST) ? 18'h0_0000 : ms_cnt_q + 18'h0_0001;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Cycle-by-cycle limit
   always @(posedge ref_clk) begin
      if (rst) begin
         cbc_q       <= CBC_RUN;
         retry_cnt_q <= 3'h0;
      end else begin
         case (cbc_q)
            CBC_RUN: begin
               retry_cnt_q <= 3'h0;
               if (cbc_event && cbc_act) begin
                  cbc_q <= CBC_HOLD;
               end
            end
            CBC_HOLD: begin
               if (!cbc_act || lk_q != LK_IDLE) begin
                  cbc_q <= CBC_RUN;
               end else if (cbc_mode[2:1] == 2'h1 && high_side_modulation) begin
                  if (!over_cbc) begin
                     cbc_q <= CBC_RUN;
                  end
               end else if (cbc_mode[2:1] == 2'h2) begin
                  if (pwm_cycle_start) begin
                     if (retry_cnt_q >= cbc_retry) begin
                        cbc_q <= CBC_RUN;
                     end else begin
                        retry_cnt_q <= retry_cnt_q + 3'h1;
                     end
                  end
               end else if (pwm_cycle_start) begin
                  cbc_q <= CBC_RUN;
               end
            end
            default: cbc_q <= CBC_RUN;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Lock detection
   always @(posedge ref_clk) begin
      if (rst) begin
         lk_q      <= LK_IDLE;
         deg_cnt_q <= 16'h0000;
         lk_ms_q   <= 16'h0000;
      end else begin
         if (!(lk_on && over_lock) || lk_q != LK_IDLE || lk_found) begin
            deg_cnt_q <= 16'h0000;
         end else if (ms_tick_q && deg_cnt_q != 16'hFFFF) begin
            deg_cnt_q <= deg_cnt_q + 16'h0001;
         end
         case (lk_q)
            LK_IDLE: begin
               lk_ms_q <= 16'h0000;
               if (lk_found && lk_mode < 4'h4) begin
                  lk_q <= LK_LATCH;
               end else if (lk_found && lk_mode < `CLFR_LOCK_REPORT) begin
                  lk_q <= LK_RETRY;
               end
            end
            LK_LATCH: begin
               if (fault_clr) begin
                  lk_q <= LK_IDLE;
               end
            end
            LK_RETRY: begin
               if (ms_tick_q) begin
                  if (lk_ms_q >= `CLFR_LOCK_RETRY_MS - 16'h0001) begin
                     lk_q <= LK_IDLE;
                  end else begin
                     lk_ms_q <= lk_ms_q + 16'h0001;
                  end
               end
            end
            default: lk_q <= LK_IDLE;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Bridge and fault pin
   reg [2:0] br_sel_d;
   reg [2:0] hs_d;
   reg [2:0] ls_d;
   reg       pin_d;

   always @* begin
      br_sel_d = BR_NORMAL;
      pin_d    = 1'b0;
      if (lk_q != LK_IDLE) begin
         br_sel_d = lock_state(lk_mode[1:0]);
         pin_d    = (lk_q == LK_LATCH);
      end else if (cbc_q == CBC_HOLD) begin
         br_sel_d = BR_RECIRC;
         pin_d    = !cbc_mode[0];
      end
      case (br_sel_d)
         BR_TRI: begin
            hs_d = 3'h0;
            ls_d = 3'h0;
         end
         BR_RECIRC: begin
            hs_d = 3'h0;
            ls_d = drive_hs | drive_ls;
         end
         BR_HSBRK: begin
            hs_d = 3'h7;
            ls_d = 3'h0;
         end
         BR_LSBRK: begin
            hs_d = 3'h0;
            ls_d = 3'h7;
         end
         default: begin
            hs_d = drive_hs;
            ls_d = drive_ls;
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         br_sel_q                <= BR_NORMAL;
         gate_hs_q               <= 3'h0;
         gate_ls_q               <= 3'h0;
         fault_indicator_pin_n_q <= 1'b1;
      end else begin
         br_sel_q                <= br_sel_d;
         gate_hs_q               <= hs_d;
         gate_ls_q               <= ls_d;
         fault_indicator_pin_n_q <= !pin_d;
      end
   end

endmodule // clfr_top

`default_nettype wire

// [verif/clfr_chk.sv]
// Port checker for clfr_top: bus handshake and fault responses.
// Assumes bind to clfr_top; settings tracked from bus writes.
`include "clfr_defs.vh"
`default_nettype none
module clfr_chk #(parameter int ADC_W = 12) (
   input wire logic             ref_clk,
   input wire logic             rst,
   input wire logic [7:0]       avs_address,
   input wire logic             avs_read,
   input wire logic             avs_write,
   input wire logic [31:0]      avs_writedata,
   input wire logic             avs_waitrequest,
   input wire logic [ADC_W-1:0] sense_amp_output_voltage,
   input wire logic [ADC_W-1:0] cycle_limit_threshold,
   input wire logic             pwm_cycle_start,
   input wire logic [2:0]       drive_hs,
   input wire logic [2:0]       drive_ls,
   input wire logic [2:0]       gate_hs_q,
   input wire logic [2:0]       gate_ls_q,
   input wire logic             fault_indicator_pin_n_q
);
   logic [31:0] setup_q;
   logic [31:0] cfg_q;
   logic [1:0]  age_q;
   logic [2:0]  clr_q;
   wire logic [3:0] lim = cfg_q[26:23];
   wire logic [3:0] lck = cfg_q[18:15];
   wire logic       lk_off = cfg_q[22:19] == 4'h0 || lck > 4'h8;
   wire logic       req = avs_read || avs_write;
   wire logic       pin_n = fault_indicator_pin_n_q;
   //////////////////////////////////////////////////////////////////////////////
   // Working copy of the settings, age since change, clear window
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         setup_q <= 32'h0000_0000;
         cfg_q   <= 32'h0000_0000;
         age_q   <= 2'h0;
         clr_q   <= 3'h0;
      end else begin
         if (avs_write && !avs_waitrequest && avs_address == `CLFR_OFS_SETUP) begin
            setup_q <= avs_writedata;
         end
         if (pwm_cycle_start) begin
            cfg_q <= setup_q;
         end
         age_q <= (pwm_cycle_start && setup_q != cfg_q) ? 2'h0 : (age_q == 2'h3 ? age_q : age_q + 2'h1);
         clr_q <= (avs_write && avs_address == `CLFR_OFS_CONTROL) ? 3'h4 : (clr_q == 3'h0 ? clr_q : clr_q - 3'h1);
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_req;
      req && avs_waitrequest;
   endsequence
   sequence s_over;
      lim == 4'h0 && lk_off && sense_amp_output_voltage > cycle_limit_threshold && !pwm_cycle_start;
   endsequence
   sequence s_no_pwm;
      !pwm_cycle_start [*2];
   endsequence
   a_ack_after_req: assert property (s_req |=> !avs_waitrequest) else $error("ack missing");
   a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack too long");
   a_no_spur_ack: assert property (!req |=> avs_waitrequest) else $error("ack without request");
   a_lim_flag: assert property (s_over ##1 s_no_pwm |-> !pin_n && gate_hs_q == 3'h0)
      else $error("limit response missing");
   a_lim_quiet: assert property (lim == 4'h1 && lk_off && age_q == 2'h3 |-> pin_n)
      else $error("fault pin raised");
   a_report_only: assert property (lim == 4'h6 && lk_off && age_q == 2'h3
      |-> pin_n && gate_hs_q == $past(drive_hs)) else $error("report mode acted");
   a_pass_thru: assert property (lim > 4'h6 && lk_off && age_q == 2'h3 && pin_n
      |-> gate_ls_q == $past(drive_ls)) else $error("gates not passed through");
   a_hs_brake: assert property (!pin_n && lim > 4'h6 && lck == 4'h2 && cfg_q[22:19] != 4'h0
      |-> gate_hs_q == 3'h7 && gate_ls_q == 3'h0) else $error("brake gates wrong");
   a_latch_hold: assert property (!pin_n && lim > 4'h6 && lck < 4'h4 && cfg_q[22:19] != 4'h0
      && clr_q == 3'h0 |=> !pin_n) else $error("latched fault dropped");
endmodule // clfr_chk
bind clfr_top clfr_chk #(.ADC_W(ADC_W)) chk (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .sense_amp_output_voltage(sense_amp_output_voltage), .cycle_limit_threshold(cycle_limit_threshold),
   .pwm_cycle_start(pwm_cycle_start), .drive_hs(drive_hs), .drive_ls(drive_ls), .gate_hs_q(gate_hs_q),
   .gate_ls_q(gate_ls_q), .fault_indicator_pin_n_q(fault_indicator_pin_n_q));
`default_nettype wire

// [verif/clfr_stage.sv]
// Power stage and sense amplifier model: PWM cycle starts and sense level.
// Assumes the bench sets the sensed current level.
`default_nettype none
module clfr_stage #(parameter int PWM_P = 50, parameter int ADC_W = 12) (
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic [ADC_W-1:0]  sense_lvl,
   output var logic              pwm_cycle_start,
   output wire logic [ADC_W-1:0] sense_amp_output_voltage
);
   int cnt_q;
   // Sense amplifier output always driven, follows the phase current
   assign sense_amp_output_voltage = sense_lvl;
   always_ff @(posedge ref_clk) begin
      cnt_q <= (rst || cnt_q == PWM_P - 1) ? 0 : cnt_q + 1;
      pwm_cycle_start <= !rst && cnt_q == PWM_P - 1;
   end
endmodule // clfr_stage
`default_nettype wire

// [verif/clfr_top_bench.sv]
// Self-checking bench for clfr_top: registers, cycle limit and lock responses.
// Assumes clfr_stage as far side and clfr_chk bound to dut.
`include "clfr_defs.vh"
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %0s exp %h got %h", n, e, g); end end
module clfr_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 0, rst = 1, rd = 0, wr = 0, wrq, pwm, pin_n, irq;
   logic [7:0]  adr = 0;
   logic [31:0] wd = 0, rdat, x = 32'h0000_cb8e, v, e, m;
   logic [11:0] sl = 0, sv, thr = 12'h0100;
   logic [2:0]  dhs = 0, dls = 0, ghs, gls;
   logic [3:0]  c;
   logic        h, hsm = 1;
   logic [31:0] eq[$], mq[$];
   int          bad_count = 0, num_checks = 0, cyc = 0, w;
   always #2 ref_clk = ~ref_clk;
   clfr_stage #(.PWM_P(50), .ADC_W(12)) stage (.ref_clk(ref_clk), .rst(rst), .sense_lvl(sl),
      .pwm_cycle_start(pwm), .sense_amp_output_voltage(sv));
   clfr_top #(.ADC_W(12), .MS_CYCLES(10)) dut (.ref_clk(ref_clk), .rst(rst), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wrq),
      .sense_amp_output_voltage(sv), .cycle_limit_threshold(thr), .pwm_cycle_start(pwm), .high_side_modulation(hsm),
      .drive_hs(dhs), .drive_ls(dls), .gate_hs_q(ghs), .gate_ls_q(gls), .fault_indicator_pin_n_q(pin_n), .irq_q(irq));
   function automatic logic [31:0] xs();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   always @(posedge ref_clk) begin
      cyc++;
      {dhs, dls} <= 6'(xs());
      if (cyc == 40000) begin
         bad_count++;
         summarize();
      end
   end
   // Read monitor: compares against the oldest note
   always @(posedge ref_clk) begin
      if (rd && wrq === 1'b0) begin
         e = eq.pop_front();
         m = mq.pop_front();
         `CHK("readdata", e, rdat & m)
      end
   end
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do @(posedge ref_clk); while (wrq !== 1'b0);
      rd <= 0;
      wr <= 0;
      @(posedge ref_clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
      eq.push_back(ex & mk);
      mq.push_back(mk);
      bus(a, 1'b0, 32'h0000_0000);
   endtask
   task automatic pw();
      do @(posedge ref_clk); while (pwm !== 1'b1);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 0;
      for (int i = 0; i < 5; i++) rdc(8'(4 * i), 32'h0000_0000, 32'hFFFF_FFFF);
      bus(8'h20, 1'b1, xs());
      rdc(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
      v = xs();
      bus(`CLFR_OFS_SETUP, 1'b1, v);
      rdc(`CLFR_OFS_SETUP, v, 32'hFFFF_FFFF);
      bus(`CLFR_OFS_MASK, 1'b1, 32'h0000_0003);
      $display("test registers done");
      // New setting must wait for the next PWM cycle start
      bus(`CLFR_OFS_SETUP, 1'b1, {5'h00, 4'h7, 4'h0, 4'hF, 4'h0, 3'h0, 8'h00});
      pw();
      bus(`CLFR_OFS_SETUP, 1'b1, 32'h0000_0000);
      sl <= 12'h0200;
      repeat (4) @(posedge ref_clk);
      `CHK("apply_early", 2'h2, {pin_n, irq})
      pw();
      repeat (3) @(posedge ref_clk);
      `CHK("apply_pwm", 1'b0, pin_n)
      sl <= 12'h0000;
      bus(`CLFR_OFS_STATUS, 1'b1, 32'h0000_0001);
      $display("test apply done");
      for (int i = 0; i < 9; i++) begin
         c = (i == 8) ? 4'hF : 4'(i);
         hsm <= i[0];
         bus(`CLFR_OFS_SETUP, 1'b1, {5'h00, c, 4'h0, 4'hF, 4'h0, 3'h1, 8'h00});
         pw();
         sl <= 12'h0200;
         repeat (4) @(posedge ref_clk);
         h = c < 4'h6;
         rdc(`CLFR_OFS_STATE, {25'h0, h ? 3'h2 : 3'h0, h && !c[0], 3'h0}, 32'h0000_0078);
         `CHK("irq_limit", c < 4'h7, irq)
         sl <= 12'h0000;
         bus(`CLFR_OFS_STATUS, 1'b1, 32'h0000_0001);
         repeat (2) @(posedge ref_clk);
         `CHK("irq_clear", 1'b0, irq)
         // Codes 2h/3h leave early only with high-side modulation
         h = c < 4'h6 && !(c[2:1] == 2'h1 && hsm);
         rdc(`CLFR_OFS_STATE, {25'h0, h ? 3'h2 : 3'h0, h && !c[0], 3'h0}, 32'h0000_0078);
         pw();
         repeat (4) @(posedge ref_clk);
         h = c == 4'h4 || c == 4'h5;
         rdc(`CLFR_OFS_STATE, {25'h0, h ? 3'h2 : 3'h0, h && !c[0], 3'h0}, 32'h0000_0078);
      end
      $display("test cycle limit done");
      for (int i = 0; i < 10; i++) begin
         c = 4'(i);
         w = (i % 3 == 0) ? `CLFR_DEG_MS_0 : ((i % 3 == 1) ? `CLFR_DEG_MS_1 : `CLFR_DEG_MS_2);
         bus(`CLFR_OFS_SETUP, 1'b1, {5'h00, 4'h7, 4'h2, c, 4'(i % 3), 3'h0, 8'h00});
         pw();
         sl <= 12'h0C8;
         repeat (10 * w - 4) @(posedge ref_clk);
         `CHK("pin_early", 1'b1, pin_n)
         repeat (60) @(posedge ref_clk);
         sl <= 12'h0000;
         rdc(`CLFR_OFS_STATE, {25'h0, c < 4'h8 ? 3'(c % 4 + 1) : 3'h0, c < 4'h4, c > 4'h3 && c < 4'h8, c < 4'h4, 1'b0},
             32'h0000_007E);
         rdc(`CLFR_OFS_STATUS, {30'h0, c < 4'h9, 1'b0}, 32'h0000_0002);
         `CHK("irq_lock", c < 4'h9, irq)
         bus(`CLFR_OFS_STATUS, 1'b1, 32'h0000_0002);
         bus(`CLFR_OFS_CONTROL, 1'b1, 32'h0000_0001);
         repeat ((c > 4'h3 && c < 4'h8) ? 5100 : 4) @(posedge ref_clk);
         rdc(`CLFR_OFS_STATE, 32'h0000_0000, 32'h0000_007E);
      end
      $display("test lock done");
      summarize();
   end
endmodule // clfr_top_bench
`default_nettype wire
